// file: hw/spc_checker.sv
// Sample pattern compare block with APB register access
`timescale 1ns/1ns
`include "spc_defines.svh"
// Function
// - Comparison runs while the compare-on bit 7 or the auto-clear bit 5 is set.
// - Writing one to bit 6 clears both fail flags and every error bit.
// - Auto-clear mode compares and clears errors after eight passing sets.
// - Pass flag bit 2 sets after eight matching compare sets in auto-clear mode.
// - Auto fail flag bit 1 sets on any mismatch in auto-clear mode.
// - Fail flag bit 0 sets on mismatch in either compare mode.
// - Port 0 rising errors: bits 7..0 at 0x51, 13..8 at 0x52.
// - Port 1 rising errors: bits 7..0 at 0x53, 13..8 at 0x54.
// - Port 0 falling errors: bits 7..0 at 0x55, 13..8 at 0x56.
// - Port 1 falling errors: bits 7..0 at 0x57, 13..8 at 0x58.
// - Control register reads zero after reset.
module spc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire spc_pkg::spc_link_type link_in,
    output logic irq
);
    import spc_pkg::*;

    spc_link_type sync1;
    spc_link_type sync2;
    logic clk_prev;
    logic rise;
    logic fall;
    logic active;
    logic [13:0] err [4];
    logic [3:0] hit;
    logic rise_ok;
    logic set_done;
    logic set_pass;
    logic auto_clear;
    logic [3:0] pass_cnt;
    logic on_bit;
    logic auto_bit;
    logic pass_flag;
    logic afail_flag;
    logic fail_flag;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [9:0] idx;
    logic mapped;
    logic wr;
    logic wr_lo;
    logic clear_req;
    logic any_mis;
    logic [7:0] rd_mux;
    logic rise_cmp;
    logic fall_cmp;
    logic clear_all;
    logic [3:0] load_low;
    logic [3:0] load_high;

    // Two-stage synchroniser for the link pins
    // Clock and data share both stages, so they stay aligned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= link_in;
            sync2 <= sync1;
        end
    end

    // Link clock edge finder
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= sync2.clk;
        end
    end

    assign rise = sync2.clk & ~clk_prev;
    assign fall = ~sync2.clk & clk_prev;
    assign active = on_bit | auto_bit;

    // Compare strobes and the shared clear of all error bits
    assign rise_cmp = rise & active;
    assign fall_cmp = fall & active;
    assign clear_all = clear_req | auto_clear;

    assign any_mis = |hit;
    assign set_done = fall & active;
    assign set_pass = rise_ok & ~hit[2] & ~hit[3];

    // Bus decode
    assign idx = paddr[11:2];
    assign mapped = (paddr[1:0] == 2'b00) &&
        (idx >= `SPC_IDX_CTRL) && (idx <= `SPC_IDX_IRQ_MASK);
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite & mapped;
    assign wr_lo = wr & pstrb[0];
    assign clear_req = wr_lo && (idx == `SPC_IDX_CTRL) &&
        pwdata[`SPC_BIT_CLEAR];

    // Rising half of a compare set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_ok <= 1'b0;
        end else if (rise) begin
            rise_ok <= active & ~hit[0] & ~hit[1];
        end
    end

    // Consecutive passing sets in auto-clear mode
    // Any mismatch restarts the count, so the eight sets are consecutive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pass_cnt <= 4'h0;
        end else if (!auto_bit) begin
            pass_cnt <= 4'h0;
        end else if (any_mis) begin
            pass_cnt <= 4'h0;
        end else if (set_done && set_pass) begin
            if (pass_cnt == `SPC_PASS_SETS - 4'h1) begin
                pass_cnt <= 4'h0;
            end else begin
                pass_cnt <= pass_cnt + 4'h1;
            end
        end
    end

    assign auto_clear = auto_bit && set_done && set_pass &&
        (pass_cnt == `SPC_PASS_SETS - 4'h1);

    // Pattern register selects, a low and a high byte per lane
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            load_low[k] = wr_lo && (idx == `SPC_IDX_P0R_LO + 10'(2 * k));
            load_high[k] = wr_lo && (idx == `SPC_IDX_P0R_HI + 10'(2 * k));
        end
    end

    // Port 0, rising edge lane
    spc_lane #(
        .WIDTH(14),
        .LOW_BITS(8)
    ) i_lane_p0_rise (
        .pclk(pclk),
        .presetn(presetn),
        .sample(sync2.data.p0),
        .strobe(rise_cmp),
        .load_low(load_low[0]),
        .load_high(load_high[0]),
        .wdata(pwdata[7:0]),
        .clear(clear_all),
        .err(err[0]),
        .hit(hit[0])
    );

    // Port 1, rising edge lane
    spc_lane #(
        .WIDTH(14),
        .LOW_BITS(8)
    ) i_lane_p1_rise (
        .pclk(pclk),
        .presetn(presetn),
        .sample(sync2.data.p1),
        .strobe(rise_cmp),
        .load_low(load_low[1]),
        .load_high(load_high[1]),
        .wdata(pwdata[7:0]),
        .clear(clear_all),
        .err(err[1]),
        .hit(hit[1])
    );

    // Port 0, falling edge lane
    spc_lane #(
        .WIDTH(14),
        .LOW_BITS(8)
    ) i_lane_p0_fall (
        .pclk(pclk),
        .presetn(presetn),
        .sample(sync2.data.p0),
        .strobe(fall_cmp),
        .load_low(load_low[2]),
        .load_high(load_high[2]),
        .wdata(pwdata[7:0]),
        .clear(clear_all),
        .err(err[2]),
        .hit(hit[2])
    );

    // Port 1, falling edge lane
    spc_lane #(
        .WIDTH(14),
        .LOW_BITS(8)
    ) i_lane_p1_fall (
        .pclk(pclk),
        .presetn(presetn),
        .sample(sync2.data.p1),
        .strobe(fall_cmp),
        .load_low(load_low[3]),
        .load_high(load_high[3]),
        .wdata(pwdata[7:0]),
        .clear(clear_all),
        .err(err[3]),
        .hit(hit[3])
    );

    // Control bits written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_bit <= 1'b0;
            auto_bit <= 1'b0;
        end else if (wr_lo && idx == `SPC_IDX_CTRL) begin
            on_bit <= pwdata[`SPC_BIT_ON];
            auto_bit <= pwdata[`SPC_BIT_AUTO];
        end
    end

    // Pass flag: software writable, set by an auto clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pass_flag <= 1'b0;
        end else if (auto_clear) begin
            pass_flag <= 1'b1;
        end else if (wr_lo && idx == `SPC_IDX_CTRL) begin
            pass_flag <= pwdata[`SPC_BIT_PASS];
        end
    end

    // Fail flags
    // A mismatch in the clearing cycle keeps the flag set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_flag <= 1'b0;
            afail_flag <= 1'b0;
        end else begin
            if (any_mis) begin
                fail_flag <= 1'b1;
            end else if (clear_req || auto_clear) begin
                fail_flag <= 1'b0;
            end
            if (any_mis && auto_bit) begin
                afail_flag <= 1'b1;
            end else if (clear_req || auto_clear) begin
                afail_flag <= 1'b0;
            end
        end
    end

    // Interrupt status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= 2'b00;
            irq_mask <= 2'b00;
        end else begin
            if (wr_lo && idx == `SPC_IDX_IRQ_MASK) begin
                irq_mask <= pwdata[1:0];
            end
            for (int b = 0; b < 2; b++) begin
                if ((b == `SPC_IRQ_MISMATCH && any_mis) ||
                    (b == `SPC_IRQ_AUTOPASS && auto_clear)) begin
                    irq_stat[b] <= 1'b1;
                end else if (wr_lo && idx == `SPC_IDX_IRQ_STAT && pwdata[b]) begin
                    irq_stat[b] <= 1'b0;
                end
            end
        end
    end

    // Level interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // Read mux; reserved bits read zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (idx)
            `SPC_IDX_CTRL: rd_mux = {on_bit, 1'b0, auto_bit, 2'b00,
                pass_flag, afail_flag, fail_flag};
            `SPC_IDX_P0R_LO: rd_mux = err[0][7:0];
            `SPC_IDX_P0R_HI: rd_mux = {2'b00, err[0][13:8]};
            `SPC_IDX_P1R_LO: rd_mux = err[1][7:0];
            `SPC_IDX_P1R_HI: rd_mux = {2'b00, err[1][13:8]};
            `SPC_IDX_P0F_LO: rd_mux = err[2][7:0];
            `SPC_IDX_P0F_HI: rd_mux = {2'b00, err[2][13:8]};
            `SPC_IDX_P1F_LO: rd_mux = err[3][7:0];
            `SPC_IDX_P1F_HI: rd_mux = {2'b00, err[3][13:8]};
            `SPC_IDX_IRQ_STAT: rd_mux = {6'h00, irq_stat};
            `SPC_IDX_IRQ_MASK: rd_mux = {6'h00, irq_mask};
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data and error answer latched in the setup phase
    // Latching in setup lets pready stay high with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= (mapped && !pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
            pslverr <= !mapped;
        end
    end

endmodule // spc_checker

// One compare lane: expected word, mismatch and sticky error bits
module spc_lane #(
    parameter int WIDTH = 14,
    parameter int LOW_BITS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] sample,
    input wire logic strobe,
    input wire logic load_low,
    input wire logic load_high,
    input wire logic [LOW_BITS-1:0] wdata,
    input wire logic clear,
    output logic [WIDTH-1:0] err,
    output logic hit
);
    logic [WIDTH-1:0] patt;
    logic [WIDTH-1:0] mis;

    // Expected word, loaded one byte register at a time
    // Pattern is write-only; reads return the error bits instead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            patt <= `SPC_PATT_RESET;
        end else begin
            if (load_low) begin
                patt[LOW_BITS-1:0] <= wdata;
            end
            if (load_high) begin
                patt[WIDTH-1:LOW_BITS] <= wdata[WIDTH-LOW_BITS-1:0];
            end
        end
    end

    // Mismatching bits, only on this lane's edge strobe
    assign mis = (sample ^ patt) & {WIDTH{strobe}};
    assign hit = |mis;

    // Sticky error bits; a new mismatch beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err <= '0;
        end else begin
            err <= (err & ~{WIDTH{clear}}) | mis;
        end
    end

endmodule // spc_lane

// file: hw/spc_defines.svh
// Offsets, field positions, reset values and counts of the sample checker
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// Register indices; byte address is four times the index
`define SPC_IDX_CTRL 10'h050
`define SPC_IDX_P0R_LO 10'h051
`define SPC_IDX_P0R_HI 10'h052
`define SPC_IDX_P1R_LO 10'h053
`define SPC_IDX_P1R_HI 10'h054
`define SPC_IDX_P0F_LO 10'h055
`define SPC_IDX_P0F_HI 10'h056
`define SPC_IDX_P1F_LO 10'h057
`define SPC_IDX_P1F_HI 10'h058
`define SPC_IDX_IRQ_STAT 10'h059
`define SPC_IDX_IRQ_MASK 10'h05a

// Control register fields
`define SPC_BIT_ON 7
`define SPC_BIT_CLEAR 6
`define SPC_BIT_AUTO 5
`define SPC_BIT_PASS 2
`define SPC_BIT_AFAIL 1
`define SPC_BIT_FAIL 0

// Interrupt status fields
`define SPC_IRQ_MISMATCH 0
`define SPC_IRQ_AUTOPASS 1

// Reset values
`define SPC_CTRL_RESET 8'h00
`define SPC_PATT_RESET 14'h0000

// Passing sets before an automatic clear
`define SPC_PASS_SETS 4'h8

`endif

// file: hw/spc_pkg.sv
// Types shared by the sample checker
package spc_pkg;

    // One word from each data port
    typedef struct packed {
        logic [13:0] p1;
        logic [13:0] p0;
    } spc_sample_type;

    // Link pins as seen by the checker
    typedef struct packed {
        logic clk;
        spc_sample_type data;
    } spc_link_type;

endpackage

// file: dv/spc_checker_chk.sv
// Bus-port assertions of the sample checker
`timescale 1ns/1ns
module spc_checker_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup cycle and refused-address decode
    wire logic su = psel && !penable;
    wire logic off = paddr[11:2] < 10'h050 || paddr[11:2] > 10'h05a || paddr[1:0] != 2'h0;
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("prdata upper bits set");
    chk_bad_refused: assert property (su && off |=> pslverr && prdata == 32'h0)
        else $error("bad address not refused");
    chk_good_taken: assert property (su && !off |=> !pslverr)
        else $error("good address refused");
    chk_read_stands: assert property (!su |=> $stable(prdata) && $stable(pslverr))
        else $error("read data moved");
    chk_hi_reserved: assert property (su && paddr inside {12'h148, 12'h150, 12'h158, 12'h160} |=> prdata[7:6] == 2'h0)
        else $error("high reserved bits set");
    chk_ctrl_reserved: assert property (su && paddr == 12'h140 |=> !prdata[6] && prdata[4:3] == 2'h0)
        else $error("control reserved bits set");
    chk_fail_pair: assert property (su && paddr == 12'h140 |=> !prdata[1] || prdata[0])
        else $error("auto fail without fail");
endmodule // spc_checker_chk

bind spc_checker spc_checker_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// file: dv/spc_host_model.sv
// Host-side model driving the double-data-rate sample link
`timescale 1ns/1ns
module spc_host_model (
    input wire logic run,
    input wire spc_pkg::spc_sample_type rise_word,
    input wire spc_pkg::spc_sample_type fall_word,
    output spc_pkg::spc_link_type link
);
    import spc_pkg::*;
    // Free-phase 800 ns clock; data moves mid-half, clock parks when idle
    initial begin
        link = '0;
        #37;
        forever begin
            #200;
            link.data = run ? (link.clk ? fall_word : rise_word) : ~link.data;
            #200;
            link.clk = run ? ~link.clk : link.clk;
        end
    end
endmodule // spc_host_model

// file: dv/spc_tb.sv
// Self-checking bench of the sample checker
`timescale 1ns/1ns
module testbench;
    import spc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, pready, pslverr, irq;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, seed = 32'hcc21fc85;
    logic [13:0] w [4], fl [4];
    logic [32:0] expq [$];
    spc_sample_type rise_word = 0, fall_word = 0;
    spc_link_type link;
    int n_errors = 0, num_checks = 0;
    always #50 pclk = ~pclk;
    spc_checker i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_in(link), .irq(irq));
    spc_host_model i_host (.run(run), .rise_word(rise_word), .fall_word(fall_word), .link(link));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [32:0] g, input logic [32:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Takes the oldest note at each completed read
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp("prdata", {pslverr, prdata}, expq.pop_front());
    end
    // One bus transfer, held until ready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        if (!wr) expq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_errors++;
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d);
        apb(1'b0, a, d, {25'h0, d});
    endtask
    // Reads all eight error registers
    task automatic chk_errs(input logic on);
        for (int k = 0; k < 4; k++) begin
            rd(12'h144 + 12'(8 * k), on ? fl[k][7:0] : 8'h0);
            rd(12'h148 + 12'(8 * k), on ? {2'b0, fl[k][13:8]} : 8'h0);
        end
    endtask
    task automatic chk_irq(input logic e);
        @(negedge pclk);
        cmp("irq", {32'h0, irq}, {32'h0, e});
        @(posedge pclk);
    endtask
    // Host words, with the flip masks when bad
    task automatic drive(input logic bad);
        logic [13:0] m;
        m = bad ? 14'h3fff : 14'h0;
        rise_word <= {w[1] ^ fl[1] & m, w[0] ^ fl[0] & m};
        fall_word <= {w[3] ^ fl[3] & m, w[2] ^ fl[2] & m};
    endtask
    task automatic lwait(input int n);
        repeat (n) @(posedge link.clk);
        repeat (6) @(posedge pclk);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        fl = '{14'h0001, 14'h0100, 14'h2000, 14'h0080};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h140, 8'h00);
        chk_errs(1'b0);
        apb(1'b0, 12'h100, 8'h0, {1'b1, 32'h0});
        apb(1'b0, 12'h141, 8'h0, {1'b1, 32'h0});
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            w[k] = seed[13:0];
            wr(12'h144 + 12'(8 * k), w[k][7:0]);
            wr(12'h148 + 12'(8 * k), {2'b11, w[k][13:8]});
        end
        drive(1'b1);
        run <= 1'b1;
        lwait(4);
        rd(12'h140, 8'h00);
        chk_errs(1'b0);
        wr(12'h140, 8'h80);
        lwait(4);
        rd(12'h140, 8'h81);
        chk_errs(1'b1);
        chk_irq(1'b0);
        wr(12'h168, 8'h01);
        chk_irq(1'b1);
        drive(1'b0);
        lwait(2);
        wr(12'h140, 8'hc0);
        rd(12'h140, 8'h80);
        chk_errs(1'b0);
        rd(12'h164, 8'h01);
        wr(12'h164, 8'h01);
        chk_irq(1'b0);
        wr(12'h140, 8'h20);
        drive(1'b1);
        lwait(3);
        rd(12'h140, 8'h23);
        drive(1'b0);
        lwait(5);
        rd(12'h140, 8'h23);
        lwait(7);
        rd(12'h140, 8'h24);
        chk_errs(1'b0);
        rd(12'h164, 8'h03);
        chk_irq(1'b1);
        tally_and_finish();
    end
endmodule // testbench
